/* hw/eag_top.v */
// Purpose: effective address and next pc for one instruction
// Assumes: caller presents opcode then operand bytes with strobes
// Notes:   one instruction in flight; all outputs registered
`include "eag_consts.vh"
// Behaviour
// RL1: ten addressing modes, one per opcode
// RL2: address is where operand read or written
// RL3: inherent is one byte, no operands
// RL4: immediate address pc+1, pc advances two
// RL5: direct zero high byte, operand low
// RL6: extended first byte high, second low
// RL7: indexed no offset uses x, pc+1
// RL8: 8-bit offset x+byte, carry high
// RL9: 16-bit offset adds carry to high
// RL10: relative branch adds signed byte to pc+2
// RL11: bit-test copies tested bit to carry
// RL12: stop runs as nop, mask unchanged
// RL13: address combinational, pc updated after fetch; effective_address is registered with next_pc_out
module eag_top (
    input  wire        clk,
    input  wire        rstn,
    input  wire        ce,
    input  wire        op_valid,
    input  wire [7:0]  opcode,
    input  wire [15:0] pc,
    input  wire [7:0]  index_x,
    input  wire        byte_valid,
    input  wire [7:0]  operand_byte,
    input  wire        branch_cond,
    input  wire        mem_bit_valid,
    input  wire        mem_bit,
    output reg  [15:0] effective_address,
    output reg         ea_valid,
    output reg  [15:0] next_pc_out,
    output reg         done,
    output reg  [3:0]  mode_out,
    output reg         is_nop,
    output reg         carry_load,
    output reg         carry_value
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire [`EAG_MODE_W-1:0] dec_mode;
    wire [1:0]             dec_len;
    wire                   dec_stop;
    eag_mode_decode u_dec (
        .opcode      (opcode),
        .mode        (dec_mode),
        .len         (dec_len),
        .stop_as_nop (dec_stop)
    );
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg [1:0]  state;
    reg [3:0]  mode;
    reg [1:0]  len;
    reg [15:0] op_pc;
    reg [7:0]  b1;
    reg [7:0]  b2;
    reg [7:0]  xr;
    reg        cond;
    reg [1:0]  next_state;
    // ------------------------------------------------------------
    // address arithmetic
    // ------------------------------------------------------------
    function [15:0] calc_ea;
        input [3:0]  m;
        input [15:0] p;
        input [7:0]  a;
        input [7:0]  b;
        input [7:0]  x;
        reg   [8:0]  s;
        begin
            s = {1'b0, x} + {1'b0, (m == `EAG_MODE_IX2) ? b : a};
            case (m)
                `EAG_MODE_IMM: calc_ea = p + 16'h0001;                        // RL4
                `EAG_MODE_DIR,
                `EAG_MODE_BSC,
                `EAG_MODE_BTB: calc_ea = {`EAG_ZERO_BYTE, a};                 // RL5
                `EAG_MODE_EXT: calc_ea = {a, b};                              // RL6
                `EAG_MODE_IX:  calc_ea = {`EAG_ZERO_BYTE, x};                 // RL7
                `EAG_MODE_IX1: calc_ea = {7'h00, s};                          // RL8
                `EAG_MODE_IX2: calc_ea = {a + {7'h00, s[8]}, s[7:0]};         // RL9
                `EAG_MODE_REL: calc_ea = p + 16'h0002 + {{8{a[7]}}, a};       // RL10
                default:       calc_ea = `EAG_ZERO_ADDR;                      // RL3
            endcase
        end
    endfunction
    wire [15:0] ea_now = calc_ea(mode, op_pc, b1, b2, xr); // RL2 RL13
    wire [15:0] seq_pc = op_pc + {14'h0000, len};
    wire        branch_mode = (mode == `EAG_MODE_REL) || (mode == `EAG_MODE_BTB);
    wire [15:0] btb_tgt = op_pc + 16'h0003 + {{8{b2[7]}}, b2};
    wire [15:0] tgt = (mode == `EAG_MODE_BTB) ? btb_tgt : ea_now;
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            `EAG_ST_IDLE: if (op_valid) next_state = (dec_len == `EAG_LEN_1) ? `EAG_ST_DONE : `EAG_ST_OP1;
            `EAG_ST_OP1:  if (byte_valid) next_state = (len == `EAG_LEN_3) ? `EAG_ST_OP2 : `EAG_ST_DONE;
            `EAG_ST_OP2:  if (byte_valid && (mode != `EAG_MODE_BTB || mem_bit_valid)) next_state = `EAG_ST_DONE;
            `EAG_ST_DONE: next_state = `EAG_ST_IDLE;
            default:      next_state = `EAG_ST_IDLE;
        endcase
    end
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= `EAG_ST_IDLE;
            mode <= `EAG_MODE_INH;
            len <= `EAG_LEN_1;
            op_pc <= `EAG_ZERO_ADDR;
            b1 <= `EAG_ZERO_BYTE;
            b2 <= `EAG_ZERO_BYTE;
            xr <= `EAG_ZERO_BYTE;
            cond <= 1'b0;
            effective_address <= `EAG_ZERO_ADDR;
            ea_valid <= 1'b0;
            next_pc_out <= `EAG_ZERO_ADDR;
            done <= 1'b0;
            mode_out <= `EAG_MODE_INH;
            is_nop <= 1'b0;
            carry_load <= 1'b0;
            carry_value <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            ea_valid <= 1'b0;
            done <= 1'b0;
            carry_load <= 1'b0;
            case (state)
                `EAG_ST_IDLE: if (op_valid) begin
                    mode <= dec_mode;
                    len <= dec_len;
                    op_pc <= pc;
                    xr <= index_x;
                    b1 <= `EAG_ZERO_BYTE;
                    b2 <= `EAG_ZERO_BYTE;
                    cond <= ~opcode[0];
                    is_nop <= dec_stop || (opcode == `EAG_OP_NOP); // RL12
                    mode_out <= dec_mode;
                end
                `EAG_ST_OP1: if (byte_valid) b1 <= operand_byte;
                `EAG_ST_OP2: if (byte_valid) begin
                    b2 <= operand_byte;
                    if (mode == `EAG_MODE_BTB && mem_bit_valid) begin
                        carry_load <= 1'b1;                      // RL11
                        carry_value <= mem_bit;                  // RL11
                        cond <= (cond == mem_bit);
                    end
                end
                `EAG_ST_DONE: begin
                    effective_address <= ea_now;                 // RL13
                    ea_valid <= (mode != `EAG_MODE_INH) && !branch_mode;
                    done <= 1'b1;
                    if (branch_mode && ((mode == `EAG_MODE_REL) ? branch_cond : cond)) begin
                        next_pc_out <= tgt;                      // RL10
                    end else begin
                        next_pc_out <= seq_pc;                   // RL4 RL6 RL7 RL8 RL9 RL13
                    end
                    if (mode == `EAG_MODE_BTB) begin
                        effective_address <= {`EAG_ZERO_BYTE, b1};
                    end
                end
                default: ;
            endcase
        end
    end
endmodule // eag_top

/* hw/eag_consts.vh */
// Purpose: constants for the effective-address generator
// Assumes: 8-bit cpu, 16-bit address bus
// Notes:   mode codes are internal to this block
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH
`define EAG_MODE_W      4
`define EAG_MODE_INH    4'h0
`define EAG_MODE_IMM    4'h1
`define EAG_MODE_DIR    4'h2
`define EAG_MODE_EXT    4'h3
`define EAG_MODE_IX     4'h4
`define EAG_MODE_IX1    4'h5
`define EAG_MODE_IX2    4'h6
`define EAG_MODE_REL    4'h7
`define EAG_MODE_BSC    4'h8
`define EAG_MODE_BTB    4'h9
`define EAG_MODE_BAD    4'hf
`define EAG_LEN_1       2'h1
`define EAG_LEN_2       2'h2
`define EAG_LEN_3       2'h3
`define EAG_OP_STOP     8'h8e
`define EAG_OP_NOP      8'h9d
`define EAG_ZERO_BYTE   8'h00
`define EAG_ZERO_ADDR   16'h0000
`define EAG_ST_IDLE     2'h0
`define EAG_ST_OP1      2'h1
`define EAG_ST_OP2      2'h2
`define EAG_ST_DONE     2'h3
`endif

/* hw/eag_mode_decode.v */
// Purpose: opcode to addressing mode and length
// Assumes: opcode map column layout by high nibble
// Notes:   combinational only
`include "eag_consts.vh"
module eag_mode_decode (
    input  wire [7:0]             opcode,
    output reg  [`EAG_MODE_W-1:0] mode,
    output reg  [1:0]             len,
    output wire                   stop_as_nop
);
    assign stop_as_nop = (opcode == `EAG_OP_STOP); // RL12
    always @* begin
        case (opcode[7:4]) // RL1
            4'h0: begin mode = `EAG_MODE_BTB; len = `EAG_LEN_3; end
            4'h1: begin mode = `EAG_MODE_BSC; len = `EAG_LEN_2; end
            4'h2: begin mode = `EAG_MODE_REL; len = `EAG_LEN_2; end
            4'h3: begin mode = `EAG_MODE_DIR; len = `EAG_LEN_2; end
            4'h6: begin mode = `EAG_MODE_IX1; len = `EAG_LEN_2; end
            4'h7: begin mode = `EAG_MODE_IX;  len = `EAG_LEN_1; end
            4'ha: begin mode = `EAG_MODE_IMM; len = `EAG_LEN_2; end
            4'hb: begin mode = `EAG_MODE_DIR; len = `EAG_LEN_2; end
            4'hc: begin mode = `EAG_MODE_EXT; len = `EAG_LEN_3; end
            4'hd: begin mode = `EAG_MODE_IX2; len = `EAG_LEN_3; end
            4'he: begin mode = `EAG_MODE_IX1; len = `EAG_LEN_2; end
            4'hf: begin mode = `EAG_MODE_IX;  len = `EAG_LEN_1; end
            default: begin mode = `EAG_MODE_INH; len = `EAG_LEN_1; end // RL3
        endcase
        if (opcode[7:4] == 4'ha && opcode[3:0] == 4'hd) begin
            mode = `EAG_MODE_REL;
        end
    end
endmodule // eag_mode_decode

/* tb/eag_props.sv */
// Purpose: port-level checks on the effective-address generator
// Assumes: mode codes as in eag_consts.vh
// Notes:   one clock domain
module eag_props (
    input logic        clk,
    input logic        rstn,
    input logic        done,
    input logic        ea_valid,
    input logic [15:0] effective_address,
    input logic [15:0] next_pc_out,
    input logic [3:0]  mode_out,
    input logic        is_nop,
    input logic        carry_load
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_done_one_cycle: assert property (done |=> !done) else $error("done longer than one cycle");
    a_ea_with_done: assert property (ea_valid |-> done) else $error("address without done");
    a_inh_no_ea: assert property (done && mode_out == 4'h0 |-> !ea_valid) else $error("inherent gave address");
    a_imm_next_pc: assert property (ea_valid && mode_out == 4'h1 |-> next_pc_out == effective_address + 16'h0001)
        else $error("immediate pc mismatch");
    a_dir_high_zero: assert property (ea_valid && mode_out == 4'h2 |-> effective_address[15:8] == 8'h00)
        else $error("direct high byte set");
    a_ix_high_zero: assert property (ea_valid && mode_out == 4'h4 |-> effective_address[15:8] == 8'h00)
        else $error("indexed high byte set");
    a_ix1_carry_only: assert property (ea_valid && mode_out == 4'h5 |-> effective_address[15:9] == 7'h00)
        else $error("offset sum too wide");
    a_nop_inherent: assert property (done && is_nop |-> mode_out == 4'h0 && !ea_valid)
        else $error("stop not run as nop");
    a_carry_btb_only: assert property (carry_load |-> mode_out == 4'h9) else $error("carry loaded outside bit test");
endmodule // eag_props

/* tb/eag_mem_model.sv */
// Purpose: operand memory seen by the fetch side
// Assumes: bench preloads bytes it fetches
// Notes:   read is combinational
module eag_mem_model (
    input  logic [15:0] addr,
    output logic [7:0]  data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    always_comb data = mem[addr];
endmodule // eag_mem_model

/* tb/tb_top.sv */
// Purpose: self-checking bench for eag_top
// Assumes: operand bytes come from the memory model
// Notes:   one instruction per run call
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, ce = 1, op_valid = 0, byte_valid = 0, branch_cond = 0, mem_bit_valid = 0, mem_bit = 0;
    logic [7:0] opcode = 8'h00, index_x = 8'h00, operand_byte;
    logic [15:0] pc = 16'h0000, fa = 16'h0000, effective_address, next_pc_out;
    logic ea_valid, done, is_nop, carry_load, carry_value;
    logic [3:0] mode_out;
    int err_count = 0, checked = 0;
    always #2.5 clk = ~clk;
    eag_mem_model eag_mem_model_i (.addr(fa), .data(operand_byte));
    eag_top eag_top_i (.clk(clk), .rstn(rstn), .ce(ce), .op_valid(op_valid), .opcode(opcode), .pc(pc),
        .index_x(index_x), .byte_valid(byte_valid), .operand_byte(operand_byte), .branch_cond(branch_cond),
        .mem_bit_valid(mem_bit_valid), .mem_bit(mem_bit), .effective_address(effective_address),
        .ea_valid(ea_valid), .next_pc_out(next_pc_out), .done(done), .mode_out(mode_out), .is_nop(is_nop),
        .carry_load(carry_load), .carry_value(carry_value));
    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one instruction: opcode, operand bytes, then wait for done
    task run(input [7:0] op, input [15:0] p, input [7:0] x, b1, b2, input int n, input bc,
             input [15:0] ea, np, input v);
        eag_mem_model_i.mem[p + 16'h0001] = b1;
        eag_mem_model_i.mem[p + 16'h0002] = b2;
        @(posedge clk);
        op_valid <= 1; opcode <= op; pc <= p; index_x <= x; branch_cond <= bc;
        @(posedge clk);
        op_valid <= 0;
        for (int i = 1; i < n; i++) begin
            fa <= p + 16'(i); byte_valid <= 1; mem_bit_valid <= 1;
            @(posedge clk);
        end
        byte_valid <= 0; mem_bit_valid <= 0;
        for (int i = 0; i < 8 && done !== 1'b1; i++) begin @(posedge clk); #1; end
        check(done, 1);
        check(next_pc_out, np);
        check(ea_valid, v);
        if (v) check(effective_address, ea);
    endtask
    task t_addr_modes;
        run(8'ha6, 16'h0100, 8'h00, 8'h55, 8'h00, 2, 0, 16'h0101, 16'h0102, 1);
        run(8'hb6, 16'h0200, 8'h00, 8'h80, 8'h00, 2, 0, 16'h0080, 16'h0202, 1);
        run(8'hc6, 16'h0300, 8'h00, 8'h12, 8'h34, 3, 0, 16'h1234, 16'h0303, 1);
        run(8'hf6, 16'h0400, 8'h9a, 8'h00, 8'h00, 1, 0, 16'h009a, 16'h0401, 1);
        run(8'he6, 16'h0500, 8'hff, 8'h02, 8'h00, 2, 0, 16'h0101, 16'h0502, 1);
        run(8'hd6, 16'h0600, 8'hf0, 8'h12, 8'h20, 3, 0, 16'h1310, 16'h0603, 1);
        run(8'h4c, 16'h0700, 8'h00, 8'h00, 8'h00, 1, 0, 16'h0000, 16'h0701, 0);
        run(8'h6c, 16'h0c00, 8'h10, 8'h20, 8'h00, 2, 0, 16'h0030, 16'h0c02, 1);
        run(8'h10, 16'h0a00, 8'h00, 8'h3c, 8'h00, 2, 0, 16'h003c, 16'h0a02, 1);
        $display("addressing modes done");
    endtask
    task t_branch_stop;
        run(8'h20, 16'h1000, 8'h00, 8'hfe, 8'h00, 2, 1, 16'h0000, 16'h1000, 0);
        run(8'h26, 16'h1100, 8'h00, 8'h10, 8'h00, 2, 0, 16'h0000, 16'h1102, 0);
        mem_bit <= 1;
        run(8'h00, 16'h2000, 8'h00, 8'h40, 8'h10, 3, 0, 16'h0000, 16'h2013, 0);
        check(carry_value, 1);
        mem_bit <= 0;
        run(8'h00, 16'h2100, 8'h00, 8'h40, 8'h10, 3, 0, 16'h0000, 16'h2103, 0);
        check(carry_value, 0);
        run(8'had, 16'h0b00, 8'h00, 8'h04, 8'h00, 2, 1, 16'h0000, 16'h0b06, 0);
        run(8'h8e, 16'h0800, 8'h00, 8'h00, 8'h00, 1, 0, 16'h0000, 16'h0801, 0);
        check(is_nop, 1);
        $display("branches and stop done");
    endtask
    // clock enable low must freeze the sequencer
    task t_freeze;
        @(posedge clk);
        ce <= 0; op_valid <= 1; opcode <= 8'h4c; pc <= 16'h0900;
        repeat (4) @(posedge clk);
        op_valid <= 0; ce <= 1;
        repeat (3) @(posedge clk);
        #1;
        check(done, 0);
        check(next_pc_out, 16'h0801);
        $display("clock enable freeze done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        t_addr_modes;
        t_branch_stop;
        t_freeze;
        final_report;
    end
    initial begin
        #20000;
        err_count++;
        final_report;
    end
endmodule // tb_top
bind eag_top eag_props eag_props_i (.clk(clk), .rstn(rstn), .done(done), .ea_valid(ea_valid),
    .effective_address(effective_address), .next_pc_out(next_pc_out), .mode_out(mode_out),
    .is_nop(is_nop), .carry_load(carry_load));
